//--- rtl/apdsp_consts.svh
// Constants of the active power signal chain
// Overview of operation
// [R1] Sample both bitstreams at 900 kHz, 16-bit output
// [R2] Gain pins 00/01/10/11 give 1/2/8/16
// [R3] High-pass removes current dc before multiply
// [R4] Phase compensation cancels high-pass phase lead
// [R5] Power is current sample times voltage sample
// [R6] Low-pass power to extract active dc term
// [R7] Long accumulation drives average power pulses
// [R8] Calibration pulse uses much shorter accumulation
// [R9] Every shared harmonic adds its active power
// [R10] Compensation active only with high-pass enabled
// [R11] Power low-pass is first order, 8.9 Hz
// [R12] Calibration rate selectable up to 2048 times
// [R13] Chain specified for 3.579545 MHz master clock; code derives the 900 kHz rate from the 250 MHz system clock
// [R14] Pulse on threshold, subtract, keep remainder
`ifndef APDSP_CONSTS_SVH
`define APDSP_CONSTS_SVH
`define APD_CLK_HZ 250000000
`define APD_MASTER_HZ 3579545
`define APD_OSR_HZ 900000
`define APD_OSR_DIV (`APD_CLK_HZ / `APD_OSR_HZ)
`define APD_DIV_W 9
`define APD_DEC_LOG2 6
`define APD_CIC_W 20
`define APD_CIC_SHIFT 3
`define APD_SAMPLE_W 16
`define APD_CUR_W 24
`define APD_HPF_SHIFT 14
`define APD_HPF_W 38
`define APD_PWR_W 40
`define APD_LPF_CORNER_MHZ 8900
`define APD_LPF_SHIFT 8
`define APD_LPF_W 48
`define APD_ACC_W 56
`define APD_F_THRESH 56'h0004_0000_0000_0000
`define APD_FIFO_W 32
`define APD_FIFO_DEPTH 4
`define APD_CF_PULSE_NS 4000
`define APD_CF_PULSE_CYC ((`APD_CF_PULSE_NS * (`APD_CLK_HZ / 1000000)) / 1000)
`define APD_CFPW_W 10
`define APD_F_PULSE_MS 100
`define APD_F_PULSE_CYC (`APD_F_PULSE_MS * (`APD_CLK_HZ / 1000))
`define APD_FPW_W 25
`endif

//--- rtl/apdsp_pkg.sv
// Types of the active power signal chain
package apdsp_pkg;
   typedef enum logic [2:0] {
      S_IDLE,
      S_FRONT,
      S_MULT,
      S_LPF,
      S_DFC
   } apdsp_state_e;
endpackage

//--- rtl/apdsp_fifo.sv
// Small sample FIFO between decimators and the power chain
`timescale 1ns/1ps
module apdsp_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rd_q];

   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

//--- rtl/apdsp_sinc.sv
// Third-order sinc decimator for one modulator bitstream
`timescale 1ns/1ps
`include "apdsp_consts.svh"
module apdsp_sinc (
   input wire logic clock,
   input wire logic nrst,
   input wire logic sample_en,
   input wire logic bit_in,
   output logic signed [`APD_SAMPLE_W-1:0] dout,
   output logic dout_valid
);
   logic signed [`APD_CIC_W-1:0] i1_q, i1_d, i2_q, i2_d, i3_q, i3_d;
   logic signed [`APD_CIC_W-1:0] z1_q, z1_d, z2_q, z2_d, z3_q, z3_d;
   logic signed [`APD_CIC_W-1:0] c1, c2, c3, sc;
   logic [`APD_DEC_LOG2-1:0] cnt_q, cnt_d;
   logic signed [`APD_SAMPLE_W-1:0] dout_d;
   logic vld_d;

   // ------------------------------------------------------------
   // Integrate at the oversampling rate, comb at the output rate
   // ------------------------------------------------------------
   always_comb begin
      i1_d = i1_q;
      i2_d = i2_q;
      i3_d = i3_q;
      z1_d = z1_q;
      z2_d = z2_q;
      z3_d = z3_q;
      cnt_d = cnt_q;
      dout_d = dout;
      vld_d = 1'b0;
      c1 = i3_q - z1_q;
      c2 = c1 - z2_q;
      c3 = c2 - z3_q;
      sc = c3 >>> `APD_CIC_SHIFT;
      // [R1] 900 kHz bitstream to 16-bit samples
      if (sample_en) begin
         // A signed one-bit literal reads as minus one, so unsigned steps here
         i1_d = bit_in ? i1_q + 1'b1 : i1_q - 1'b1;
         i2_d = i2_q + i1_q;
         i3_d = i3_q + i2_q;
         cnt_d = cnt_q + 1'b1;
         if (cnt_q == '1) begin
            z1_d = i3_q;
            z2_d = c1;
            z3_d = c2;
            vld_d = 1'b1;
            // Full positive scale would wrap one code, so clip it
            if (sc > `APD_CIC_W'(16'sh7fff)) begin
               dout_d = 16'sh7fff;
            end else begin
               dout_d = sc[`APD_SAMPLE_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         i1_q <= '0;
         i2_q <= '0;
         i3_q <= '0;
         z1_q <= '0;
         z2_q <= '0;
         z3_q <= '0;
         cnt_q <= '0;
         dout <= '0;
         dout_valid <= 1'b0;
      end else begin
         i1_q <= i1_d;
         i2_q <= i2_d;
         i3_q <= i3_d;
         z1_q <= z1_d;
         z2_q <= z2_d;
         z3_q <= z3_d;
         cnt_q <= cnt_d;
         dout <= dout_d;
         dout_valid <= vld_d;
      end
   end

   a_sinc_rate: assert property (@(posedge clock) disable iff (!nrst) // [R1]
      dout_valid |=> !dout_valid [*8])
      else $error("decimated samples too close together");
endmodule

//--- rtl/apdsp_chain.sv
// Active power signal chain: decimation, gain, high-pass, power, pulses
`timescale 1ns/1ps
`include "apdsp_consts.svh"
module apdsp_chain
   import apdsp_pkg::*;
#(
   parameter int unsigned F_PULSE_CYCLES = `APD_F_PULSE_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic current_bits_in,
   input wire logic voltage_bits_in,
   input wire logic gain_select_msb,
   input wire logic gain_select_lsb,
   input wire logic highpass_enable_in,
   input wire logic [1:0] calib_ratio_sel,
   output logic modulator_clk_out,
   output logic calib_pulse_out,
   output logic energy_pulse_a,
   output logic energy_pulse_b,
   output logic sample_overrun
);
   // ------------------------------------------------------------
   // Shared arithmetic
   // ------------------------------------------------------------
   function automatic logic signed [`APD_HPF_W-1:0] hpf_step(
      input logic signed [`APD_HPF_W-1:0] st,
      input logic signed [`APD_HPF_W-1:0] tgt);
      hpf_step = st + ((tgt - st) >>> `APD_HPF_SHIFT);
   endfunction

   function automatic logic [`APD_ACC_W:0] dfc_step(
      input logic [`APD_ACC_W-1:0] acc,
      input logic [`APD_ACC_W-1:0] inc,
      input logic [`APD_ACC_W-1:0] th);
      logic [`APD_ACC_W-1:0] sum;
      sum = acc + inc;
      if (sum >= th) begin
         dfc_step = {1'b1, sum - th};
      end else begin
         dfc_step = {1'b0, sum};
      end
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [6:0] s1_q, s2_q, s3_q, pin_q, pin_d;
   logic hpf_en, cur_bit, volt_bit;
   logic [1:0] gsel, rsel;

   // A change counts only once two later stages agree
   always_comb begin
      pin_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
      end else begin
         s1_q <= {highpass_enable_in, gain_select_msb, gain_select_lsb,
                  calib_ratio_sel, current_bits_in, voltage_bits_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end

   assign hpf_en = pin_q[6];
   assign gsel = pin_q[5:4];
   assign rsel = pin_q[3:2];
   assign cur_bit = pin_q[1];
   assign volt_bit = pin_q[0];

   // ------------------------------------------------------------
   // Oversampling divider
   // ------------------------------------------------------------
   logic [`APD_DIV_W-1:0] div_q, div_d;
   logic osr_en_q, osr_en_d, mclk_d;

   // [R13] Rate scaled from the system clock
   always_comb begin
      osr_en_d = div_q == `APD_DIV_W'(`APD_OSR_DIV - 1);
      div_d = osr_en_d ? '0 : div_q + 1'b1;
      mclk_d = div_d < `APD_DIV_W'(`APD_OSR_DIV / 2);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_q <= '0;
         osr_en_q <= 1'b0;
         modulator_clk_out <= 1'b0;
      end else begin
         div_q <= div_d;
         osr_en_q <= osr_en_d;
         modulator_clk_out <= mclk_d;
      end
   end

   // ------------------------------------------------------------
   // Decimation and sample buffer
   // ------------------------------------------------------------
   logic signed [`APD_SAMPLE_W-1:0] cur_s, volt_s;
   logic cur_vld, fifo_in_rdy, fifo_vld, fifo_rdy, ovr_d;
   logic [`APD_FIFO_W-1:0] fifo_data;

   apdsp_sinc u_sinc_cur (
      .clock(clock),
      .nrst(nrst),
      .sample_en(osr_en_q),
      .bit_in(cur_bit),
      .dout(cur_s),
      .dout_valid(cur_vld)
   );

   apdsp_sinc u_sinc_volt (
      .clock(clock),
      .nrst(nrst),
      .sample_en(osr_en_q),
      .bit_in(volt_bit),
      .dout(volt_s),
      .dout_valid()
   );

   apdsp_fifo #(
      .W(`APD_FIFO_W),
      .DEPTH(`APD_FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .nrst(nrst),
      .in_valid(cur_vld),
      .in_ready(fifo_in_rdy),
      .in_data({cur_s, volt_s}),
      .out_valid(fifo_vld),
      .out_ready(fifo_rdy),
      .out_data(fifo_data)
   );

   // Converters cannot stall, so a full buffer drops the pair
   assign ovr_d = sample_overrun | (cur_vld & ~fifo_in_rdy);

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sample_overrun <= 1'b0;
      end else begin
         sample_overrun <= ovr_d;
      end
   end

   // ------------------------------------------------------------
   // Processing sequencer and datapath
   // ------------------------------------------------------------
   apdsp_state_e state_q, state_d;
   logic signed [`APD_SAMPLE_W-1:0] raw_i_q, raw_i_d, volt_q, volt_d;
   logic signed [`APD_CUR_W-1:0] cur_q, cur_d, gained, dc1, dc2, hp_plain, comp;
   logic signed [`APD_HPF_W-1:0] d1_q, d1_d, d2_q, d2_d, tgt;
   logic signed [`APD_PWR_W-1:0] power_q, power_d;
   logic signed [`APD_LPF_W-1:0] lpf_q, lpf_d, pwr_ext;
   logic [`APD_ACC_W-1:0] facc_q, facc_d, cfacc_q, cfacc_d, inc, cf_th;
   logic [`APD_ACC_W:0] f_res, cf_res;
   logic [2:0] gain_shift;
   logic [3:0] cf_shift;
   logic f_fire_q, f_fire_d, cf_fire_q, cf_fire_d;

   assign fifo_rdy = state_q == S_IDLE;

   always_comb begin
      state_d = state_q;
      raw_i_d = raw_i_q;
      volt_d = volt_q;
      cur_d = cur_q;
      d1_d = d1_q;
      d2_d = d2_q;
      power_d = power_q;
      lpf_d = lpf_q;
      facc_d = facc_q;
      cfacc_d = cfacc_q;
      f_fire_d = 1'b0;
      cf_fire_d = 1'b0;
      // [R2] Gain pins to shift
      case (gsel)
         2'b00: gain_shift = 3'd0;
         2'b01: gain_shift = 3'd1;
         2'b10: gain_shift = 3'd3;
         default: gain_shift = 3'd4;
      endcase
      // [R12] Calibration to average pulse ratio
      case (rsel)
         2'b00: cf_shift = 4'd11;
         2'b01: cf_shift = 4'd10;
         2'b10: cf_shift = 4'd8;
         default: cf_shift = 4'd7;
      endcase
      cf_th = `APD_F_THRESH >> cf_shift;
      gained = {{(`APD_CUR_W - `APD_SAMPLE_W){raw_i_q[`APD_SAMPLE_W-1]}}, raw_i_q} <<< gain_shift;
      tgt = {gained, {`APD_HPF_SHIFT{1'b0}}};
      dc1 = d1_q[`APD_HPF_W-1:`APD_HPF_SHIFT];
      dc2 = d2_q[`APD_HPF_W-1:`APD_HPF_SHIFT];
      // [R3] Subtract tracked dc estimate
      hp_plain = gained - dc1;
      // [R4] Add back the lowpassed residue, cancelling first-order lead
      comp = dc1 - dc2;
      pwr_ext = {power_q, {`APD_LPF_SHIFT{1'b0}}};
      inc = lpf_q[`APD_LPF_W-1] ? '0 :
            {{(`APD_ACC_W - `APD_PWR_W){1'b0}}, lpf_q[`APD_LPF_W-1:`APD_LPF_SHIFT]};
      f_res = dfc_step(facc_q, inc, `APD_F_THRESH);
      cf_res = dfc_step(cfacc_q, inc, cf_th);
      case (state_q)
         S_IDLE: begin
            if (fifo_vld) begin
               raw_i_d = fifo_data[`APD_FIFO_W-1:`APD_SAMPLE_W];
               volt_d = fifo_data[`APD_SAMPLE_W-1:0];
               state_d = S_FRONT;
            end
         end
         S_FRONT: begin
            d1_d = hpf_step(d1_q, tgt);
            d2_d = hpf_step(d2_q, d1_q);
            // [R10] Compensation follows the high-pass enable
            cur_d = hpf_en ? hp_plain + comp : gained;
            state_d = S_MULT;
         end
         S_MULT: begin
            // [R5] Direct product; [R9] keeps every harmonic term
            power_d = cur_q * volt_q;
            state_d = S_LPF;
         end
         S_LPF: begin
            // [R6] [R11] One-pole low-pass, corner near 8.9 Hz
            lpf_d = lpf_q + ((pwr_ext - lpf_q) >>> `APD_LPF_SHIFT);
            state_d = S_DFC;
         end
         S_DFC: begin
            // [R7] [R8] [R14] Two accumulators, remainder kept
            facc_d = f_res[`APD_ACC_W-1:0];
            f_fire_d = f_res[`APD_ACC_W];
            cfacc_d = cf_res[`APD_ACC_W-1:0];
            cf_fire_d = cf_res[`APD_ACC_W];
            state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         raw_i_q <= '0;
         volt_q <= '0;
         cur_q <= '0;
         d1_q <= '0;
         d2_q <= '0;
         power_q <= '0;
         lpf_q <= '0;
         facc_q <= '0;
         cfacc_q <= '0;
         f_fire_q <= 1'b0;
         cf_fire_q <= 1'b0;
      end else begin
         state_q <= state_d;
         raw_i_q <= raw_i_d;
         volt_q <= volt_d;
         cur_q <= cur_d;
         d1_q <= d1_d;
         d2_q <= d2_d;
         power_q <= power_d;
         lpf_q <= lpf_d;
         facc_q <= facc_d;
         cfacc_q <= cfacc_d;
         f_fire_q <= f_fire_d;
         cf_fire_q <= cf_fire_d;
      end
   end

   // ------------------------------------------------------------
   // Pulse stretchers
   // ------------------------------------------------------------
   logic [`APD_FPW_W-1:0] fpw_q, fpw_d;
   logic [`APD_CFPW_W-1:0] cfpw_q, cfpw_d;
   logic phase_q, phase_d, ea_d, eb_d, cf_d;

   // A fire during an active pulse is dropped; rates stay far below
   always_comb begin
      fpw_d = fpw_q;
      cfpw_d = cfpw_q;
      phase_d = phase_q;
      // [R7] Alternate outputs for two-phase counters
      if (f_fire_q && fpw_q == '0) begin
         fpw_d = `APD_FPW_W'(F_PULSE_CYCLES);
         phase_d = ~phase_q;
      end else if (fpw_q != '0) begin
         fpw_d = fpw_q - 1'b1;
      end
      if (cf_fire_q && cfpw_q == '0) begin
         cfpw_d = `APD_CFPW_W'(`APD_CF_PULSE_CYC);
      end else if (cfpw_q != '0) begin
         cfpw_d = cfpw_q - 1'b1;
      end
      ea_d = (fpw_d != '0) && phase_d;
      eb_d = (fpw_d != '0) && !phase_d;
      cf_d = cfpw_d != '0;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         fpw_q <= '0;
         cfpw_q <= '0;
         phase_q <= 1'b0;
         energy_pulse_a <= 1'b0;
         energy_pulse_b <= 1'b0;
         calib_pulse_out <= 1'b0;
      end else begin
         fpw_q <= fpw_d;
         cfpw_q <= cfpw_d;
         phase_q <= phase_d;
         energy_pulse_a <= ea_d;
         energy_pulse_b <= eb_d;
         calib_pulse_out <= cf_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_chain;
      state_q == S_FRONT ##1 state_q == S_MULT ##1 state_q == S_LPF
         ##1 state_q == S_DFC ##1 state_q == S_IDLE;
   endsequence

   a_chain_seq: assert property ((state_q == S_IDLE && fifo_vld) |=> s_chain) // [R5]
      else $error("sample pass out of order");
   a_gain_x16: assert property ((state_q == S_FRONT && !hpf_en && gsel == 2'b11) // [R2]
      |=> cur_q == $signed($past(raw_i_q)) * 16)
      else $error("gain 16 wrong");
   a_gain_x8: assert property ((state_q == S_FRONT && !hpf_en && gsel == 2'b10) // [R2]
      |=> cur_q == $signed($past(raw_i_q)) * 8)
      else $error("gain 8 wrong");
   a_hpf_bypass: assert property ((state_q == S_FRONT && !hpf_en && gsel == 2'b00) // [R10]
      |=> cur_q == $signed($past(raw_i_q)))
      else $error("bypass altered current");
   a_hpf_comp: assert property ((state_q == S_FRONT && hpf_en) // [R4]
      |=> cur_q == $past(gained) - $past(dc2))
      else $error("compensated high-pass wrong");
   a_mult_exact: assert property (state_q == S_MULT // [R5]
      |=> power_q == $past(cur_q) * $past(volt_q))
      else $error("power product wrong");
   a_lpf_rise: assert property ((state_q == S_LPF && pwr_ext > lpf_q + 48'sd512) // [R6]
      |=> lpf_q > $past(lpf_q))
      else $error("low-pass not tracking");
   a_f_remain: assert property (state_q == S_DFC |=> facc_q < `APD_F_THRESH) // [R14]
      else $error("average accumulator kept threshold");
   a_cf_ratio: assert property (rsel == 2'b00 |-> cf_th == (`APD_F_THRESH >> 11)) // [R12]
      else $error("calibration ratio wrong");
   a_cf_width: assert property ((cf_fire_q && cfpw_q == '0) |=> calib_pulse_out [*8]) // [R8]
      else $error("calibration pulse too short");
   a_pulse_excl: assert property (energy_pulse_a |-> !energy_pulse_b) // [R7]
      else $error("both energy outputs high");
endmodule

//--- tb/apdsp_mod_model.sv
// Behavioural model of the two sigma-delta converters feeding the chain
`timescale 1ns/1ps
module apdsp_mod_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic mod_clk,
   input wire logic [1:0] cur_mode,
   input wire logic [1:0] volt_mode,
   output logic current_bits,
   output logic voltage_bits
);
   logic mod_clk_q;
   logic phase_q;

   // Mode 0 all zero, 1 all one, else zero-mean toggling
   function automatic logic pick(input logic [1:0] mode, input logic ph);
      case (mode)
         2'h0: pick = 1'b0;
         2'h1: pick = 1'b1;
         default: pick = ph;
      endcase
   endfunction

   always_ff @(posedge clock) begin
      mod_clk_q <= mod_clk;
      if (!nrst) begin
         phase_q <= 1'b0;
         current_bits <= 1'b0;
         voltage_bits <= 1'b0;
      end else if (mod_clk && !mod_clk_q) begin
         phase_q <= ~phase_q;
         current_bits <= pick(cur_mode, phase_q);
         voltage_bits <= pick(volt_mode, phase_q);
      end
   end
endmodule

//--- tb/test_active_power_dsp_chain.sv
// Self-checking bench of the active power chain and its sample FIFO
`timescale 1ns/1ps
module test_active_power_dsp_chain;
   localparam int F_CYC = 20;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic gain_msb = 1'b0;
   logic gain_lsb = 1'b0;
   logic hpf_en = 1'b0;
   logic [1:0] ratio = 2'h0;
   logic [1:0] cur_mode = 2'h2;
   logic [1:0] volt_mode = 2'h2;
   logic cur_bits;
   logic volt_bits;
   logic mod_clk;
   logic cf;
   logic fa;
   logic fb;
   logic ovr;
   int bad_count = 0;
   int compares = 0;

   always #2 clock = ~clock;

   apdsp_mod_model conv (.clock(clock), .nrst(nrst), .mod_clk(mod_clk), .cur_mode(cur_mode),
      .volt_mode(volt_mode), .current_bits(cur_bits), .voltage_bits(volt_bits));

   apdsp_chain #(.F_PULSE_CYCLES(F_CYC)) DUT (.clock(clock), .nrst(nrst), .current_bits_in(cur_bits),
      .voltage_bits_in(volt_bits), .gain_select_msb(gain_msb), .gain_select_lsb(gain_lsb),
      .highpass_enable_in(hpf_en), .calib_ratio_sel(ratio), .modulator_clk_out(mod_clk),
      .calib_pulse_out(cf), .energy_pulse_a(fa), .energy_pulse_b(fb), .sample_overrun(ovr));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task summarize;
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task expect_bit(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: %s", $time, what);
         bad_count++;
      end
   endtask

   task step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task outputs_quiet(input string what);
      expect_bit(cf, 1'b0, {what, " calib pulse"});
      expect_bit(fa, 1'b0, {what, " energy a"});
      expect_bit(fb, 1'b0, {what, " energy b"});
      expect_bit(ovr, 1'b0, {what, " overrun"});
   endtask

   // Bounded wait for the modulator clock to reach a level
   task wait_mod(input logic lvl, output int n);
      n = 0;
      while (mod_clk !== lvl) begin
         step(1);
         n++;
         if (n > 600) begin
            expect_bit(1'b1, 1'b0, "modulator clock stuck");
            summarize();
         end
      end
   endtask

   // Run n cycles, true if any pulse output rose
   task watch_pulses(input int n, output logic seen);
      seen = 1'b0;
      repeat (n) begin
         step(1);
         if (cf !== 1'b0 || fa !== 1'b0 || fb !== 1'b0) begin
            seen = 1'b1;
         end
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task test_reset;
      step(1);
      outputs_quiet("in reset");
      step(1);
      nrst = 1'b1;
      step(1);
      outputs_quiet("after release");
      // Divider leaves reset at phase zero, so the clock starts high
      expect_bit(mod_clk, 1'b1, "modulator clock after release");
   endtask

   task test_mod_clock;
      int hi;
      int lo;
      int skip;
      wait_mod(1'b0, skip);
      wait_mod(1'b1, skip);
      wait_mod(1'b0, hi);
      wait_mod(1'b1, lo);
      expect_bit(hi == 138, 1'b1, "modulator clock high time");
      expect_bit(hi + lo == 277, 1'b1, "modulator clock period");
   endtask

   // Negative product must accumulate nothing
   task test_negative_power;
      logic seen;
      cur_mode = 2'h1;
      volt_mode = 2'h0;
      {gain_msb, gain_lsb} = 2'h3;
      ratio = 2'h3;
      watch_pulses(17800, seen);
      expect_bit(seen, 1'b0, "pulse on negative power");
      expect_bit(ovr, 1'b0, "overrun on steady stream");
   endtask

   // Far below any threshold in this window, so no pulse and no overrun
   task test_gain_modes;
      logic seen;
      cur_mode = 2'h1;
      volt_mode = 2'h1;
      for (int g = 0; g < 4; g++) begin
         {gain_msb, gain_lsb} = 2'(g);
         hpf_en = g[0];
         ratio = 2'(3 - g);
         // Long windows hold one decimated pair for gains 1, 2 and 8, not the 4000-cycle gain 16 check
         watch_pulses((g == 3) ? 4000 : 17800, seen);
         expect_bit(seen, 1'b0, "early pulse in gain sweep");
         expect_bit(ovr, 1'b0, "overrun in gain sweep");
      end
   endtask

   task test_mid_reset;
      nrst = 1'b0;
      step(1);
      outputs_quiet("mid-run reset");
      step(1);
      nrst = 1'b1;
      step(1);
      outputs_quiet("after second release");
      expect_bit(mod_clk, 1'b1, "modulator clock after second release");
   endtask

   // One pair per decimation period passes the buffer and is popped at once
   task test_fifo_path;
      int pops;
      pops = 0;
      repeat (20000) begin
         step(1);
         if (DUT.fifo_vld === 1'b1) begin
            pops++;
            expect_bit(DUT.fifo_data === {DUT.cur_s, DUT.volt_s}, 1'b1, "fifo pair not as decimated");
            expect_bit(DUT.fifo_in_rdy, 1'b1, "fifo refused a single pair");
            step(1);
            expect_bit(DUT.fifo_vld, 1'b0, "fifo not drained by sequencer");
         end
      end
      expect_bit(pops == 1, 1'b1, "fifo pair count per decimation period");
      expect_bit(ovr, 1'b0, "overrun with a single pair buffered");
   endtask

   initial begin
      test_reset();
      test_fifo_path();
      test_mod_clock();
      test_negative_power();
      test_gain_modes();
      test_mid_reset();
      summarize();
   end
endmodule
